// *** hw/ser_regs.svh ***
// register numbers, field positions and reset values for status reporting
// Overview of operation
// - enabled event rise sets event summary bit
// - enable mask read/write; event register read only
// - completion command sets bit 0 when idle
// - read without query or abandoned reply: bit 2
// - device error sets bit 3, queues code
// - execution error sets bit 4, queues code
// - command error sets bit 5, queues code
// - remote to manual change sets bit 6
// - power up sets bit 7; bit 1 unused
// - questionable register 16 bits, no sources
// - operation condition live, event part accumulates
// - operation bit 0 tracks calibration; others empty
// - request when enabled byte bits 2,4,5 set
// - only the request starts bus activity
// - serial poll returns the status byte
// - summary is OR of event AND enable
// - byte bit 6 main summary, enable 6 ignored
// - byte bits 2,3,4,5,7 assigned; 0,1 unused
`ifndef SER_REGS_SVH
`define SER_REGS_SVH
// register selector codes on the command port
`define SER_SEL_EVT_STAT   3'h0
`define SER_SEL_EVT_EN     3'h1
`define SER_SEL_SRQ_EN     3'h2
`define SER_SEL_STB        3'h3
`define SER_SEL_QUES_COND  3'h4
`define SER_SEL_QUES_EVT   3'h5
`define SER_SEL_OPER_COND  3'h6
`define SER_SEL_OPER_EVT   3'h7
// event status bit positions
`define SER_EVT_OPC        0
`define SER_EVT_QYE        2
`define SER_EVT_DDE        3
`define SER_EVT_EXE        4
`define SER_EVT_CME        5
`define SER_EVT_URQ        6
`define SER_EVT_PON        7
// status byte bit positions
`define SER_STB_ERRQ       2
`define SER_STB_QUES       3
`define SER_STB_MAV        4
`define SER_STB_ESB        5
`define SER_STB_MSS        6
`define SER_STB_OPER       7
// operation condition bit position
`define SER_OPER_CAL       0
// reset values
`define SER_RST_BYTE       8'h00
`define SER_RST_WORD       16'h0000
`define SER_RST_PON        8'h80
`define SER_STB_SRQ_MASK   8'h34
`endif

// *** hw/ser_pkg.sv ***
// types shared by the status reporting block
package ser_pkg;
  // one command port access from the remote interpreter
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] sel;
    logic [7:0] wdata;
  } ser_cmd_s;
  // event pulses raised by the command interpreter and instrument
  typedef struct packed {
    logic opc_cmd;
    logic read_no_query;
    logic reply_abandoned;
    logic dev_err;
    logic exe_err;
    logic cmd_err;
    logic remote_to_local;
  } ser_evt_s;
  // error classes queued alongside event bits
  typedef enum logic [1:0] {
    SER_ERR_NONE,
    SER_ERR_CMD,
    SER_ERR_EXE,
    SER_ERR_DEV
  } ser_err_e;
endpackage

// *** hw/ser_evt_reg.sv ***
// generic sticky event register with enable mask and summary
`timescale 1ns/1ps
`default_nettype none
`include "ser_regs.svh"
module ser_evt_reg #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // condition input and read clear
  input  wire logic [W-1:0] cond_i,
  input  wire logic         clr_i,
  input  wire logic [W-1:0] en_i,
  // state
  output logic      [W-1:0] evt_o,
  output logic              sum_o
);
  logic [W-1:0] cond_q;

  // previous condition for rising edge capture
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cond_q <= '0;
    else
      cond_q <= cond_i;
  end

  // new rise wins over read clear, so no event is lost
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      evt_o <= '0;
    else if (clr_i)
      evt_o <= cond_i & ~cond_q;
    else
      evt_o <= evt_o | (cond_i & ~cond_q);
  end

  assign sum_o = |(evt_o & en_i);
endmodule
`default_nettype wire

// *** hw/ser_status.sv ***
// status byte, standard event, questionable and operation reporting
`timescale 1ns/1ps
`default_nettype none
`include "ser_regs.svh"
module ser_status (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // register command port from the remote interpreter
  input  wire ser_pkg::ser_cmd_s cmd_i,
  output logic           [15:0] rdata_o,
  output logic                  rvalid_o,
  // instrument events and levels
  input  wire ser_pkg::ser_evt_s evt_i,
  input  wire logic             cmds_idle_i,
  input  wire logic             calibrating_i,
  input  wire logic             err_queue_nonempty_i,
  input  wire logic             msg_avail_i,
  // serial poll over interface messages
  input  wire logic             spoll_i,
  output logic            [7:0] spoll_byte_o,
  output logic                  spoll_valid_o,
  // error code queue hand-off
  output var ser_pkg::ser_err_e err_class_o,
  output logic                  err_push_o,
  // service request line
  output logic                  srq_o
);
  logic [7:0]  esr_q;
  logic [7:0]  ese_q;
  logic [7:0]  sre_q;
  logic        opc_pend_q;
  logic [7:0]  esr_set;
  logic        esb;
  logic [7:0]  stb;
  logic        mss;
  logic [15:0] ques_evt;
  logic [15:0] oper_evt;
  logic [15:0] oper_cond;
  logic        ques_sum;
  logic        oper_sum;
  logic        rd_ques;
  logic        rd_oper;
  logic        rd_esr;
  logic        wr_ese;
  logic        wr_sre;
  logic [7:0]  sre_gate;

  // selector map on the command port, one code per register part:
  //   0 standard event register, read clears it
  //   1 standard event enable mask, set and query
  //   2 service request enable mask, set and query
  //   3 status byte, query only, same value as the poll
  //   4 questionable condition, always empty
  //   5 questionable event part, read clears it
  //   6 operation condition, live calibration flag
  //   7 operation event part, read clears it
  // writes to any code but 1 and 2 are dropped without a trace

  // true when the port asks for a read of one selector code
  function automatic logic sel_rd(input ser_pkg::ser_cmd_s c,
                                  input logic [2:0]        s);
    return c.rd && (c.sel == s);
  endfunction

  // true when the port carries a setting for one selector code
  function automatic logic sel_wr(input ser_pkg::ser_cmd_s c,
                                  input logic [2:0]        s);
    return c.wr && (c.sel == s);
  endfunction

  // summary of an event part against its enable part
  function automatic logic any_enabled(input logic [15:0] evt,
                                       input logic [15:0] en);
    return |(evt & en);
  endfunction

  // read of the event query clears that register
  assign rd_esr  = sel_rd(cmd_i, `SER_SEL_EVT_STAT);
  assign rd_ques = sel_rd(cmd_i, `SER_SEL_QUES_EVT);
  assign rd_oper = sel_rd(cmd_i, `SER_SEL_OPER_EVT);

  // setting decodes; only the two masks are writable
  assign wr_ese  = sel_wr(cmd_i, `SER_SEL_EVT_EN);
  assign wr_sre  = sel_wr(cmd_i, `SER_SEL_SRQ_EN);

  // only bits 2, 4 and 5 may call for service; bit 6 enable is ignored
  assign sre_gate = sre_q & `SER_STB_SRQ_MASK;

  // pending completion waits for the command pipe to drain
  // a completion command seen while busy is parked here, so the
  // event bit lands on the very edge the pipe reports idle, not
  // earlier; a second command while parked simply stays parked
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      opc_pend_q <= 1'b0;
    else if (evt_i.opc_cmd && !cmds_idle_i)
      opc_pend_q <= 1'b1;
    else if (cmds_idle_i)
      opc_pend_q <= 1'b0;
  end

  // event sources into the standard event register
  always_comb
  begin
    esr_set = 8'h00;
    esr_set[`SER_EVT_OPC] = cmds_idle_i &&
                            (evt_i.opc_cmd || opc_pend_q);
    esr_set[`SER_EVT_QYE] = evt_i.read_no_query ||
                            evt_i.reply_abandoned;
    esr_set[`SER_EVT_DDE] = evt_i.dev_err;
    esr_set[`SER_EVT_EXE] = evt_i.exe_err;
    esr_set[`SER_EVT_CME] = evt_i.cmd_err;
    esr_set[`SER_EVT_URQ] = evt_i.remote_to_local;
    // bit 1 has no source; power-on bit is only loaded by reset
    esr_set[1]            = 1'b0;
  end

  // sticky event bits; bit 1 has no source and stays clear
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      esr_q <= `SER_RST_PON;
    else if (rd_esr)
      esr_q <= esr_set;
    else
      esr_q <= esr_q | esr_set;
  end

  // event enable mask written by its set command
  // masks start cleared, so nothing calls for service until the
  // controller opts in with a setting
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      ese_q <= `SER_RST_BYTE;
    else if (wr_ese)
      ese_q <= cmd_i.wdata;
  end

  // service request enable mask written by its set command
  // all eight bits are kept so a query returns what was written,
  // even though only three of them gate the request
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      sre_q <= `SER_RST_BYTE;
    else if (wr_sre)
      sre_q <= cmd_i.wdata;
  end

  // one push per cycle with any error pulse toward the error code queue
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      err_push_o <= 1'b0;
    else
      err_push_o <= evt_i.cmd_err | evt_i.exe_err | evt_i.dev_err;
  end

  // error class: when several errors meet in one cycle only the
  // first of command, execution and device error is queued; the event bits still record all three
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      err_class_o <= ser_pkg::SER_ERR_NONE;
    else
    begin
      if (evt_i.cmd_err)
        err_class_o <= ser_pkg::SER_ERR_CMD;
      else if (evt_i.exe_err)
        err_class_o <= ser_pkg::SER_ERR_EXE;
      else if (evt_i.dev_err)
        err_class_o <= ser_pkg::SER_ERR_DEV;
      else
        err_class_o <= ser_pkg::SER_ERR_NONE;
    end
  end

  // questionable register has no sources wired
  ser_evt_reg #(.W(16)) u_ques (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .cond_i  (`SER_RST_WORD),
    .clr_i   (rd_ques),
    .en_i    (16'hffff),
    .evt_o   (ques_evt),
    .sum_o   (ques_sum)
  );

  // operation condition: only calibration is live
  always_comb
  begin
    oper_cond = `SER_RST_WORD;
    oper_cond[`SER_OPER_CAL] = calibrating_i;
  end

  ser_evt_reg #(.W(16)) u_oper (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .cond_i  (oper_cond),
    .clr_i   (rd_oper),
    .en_i    (16'hffff),
    .evt_o   (oper_evt),
    .sum_o   (oper_sum)
  );

  // summary and status byte; enable bit 6 is masked off
  // level summary: it stays up as long as an enabled bit is latched,
  // which the request line needs to hold until the bits are read
  assign esb = any_enabled({8'h00, esr_q}, {8'h00, ese_q});
  always_comb
  begin
    stb = 8'h00;
    stb[`SER_STB_ERRQ] = err_queue_nonempty_i;
    stb[`SER_STB_QUES] = ques_sum;
    stb[`SER_STB_MAV]  = msg_avail_i;
    stb[`SER_STB_ESB]  = esb;
    stb[`SER_STB_OPER] = oper_sum;
    // enables 1 and 32 route a completion through bit 5 to a request
    mss = any_enabled({8'h00, stb}, {8'h00, sre_gate});
    stb[`SER_STB_MSS]  = mss;
  end

  // request line only; nothing else leaves on its own
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      srq_o <= 1'b0;
    else
      srq_o <= mss;
  end

  // serial poll strobe answered one cycle later
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      spoll_valid_o <= 1'b0;
    else
      spoll_valid_o <= spoll_i;
  end

  // serial poll answer mirrors the status byte query
  // the byte is held after the poll so a slow reader still sees it
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      spoll_byte_o <= `SER_RST_BYTE;
    else if (spoll_i)
      spoll_byte_o <= stb;
  end

  // query strobe answered one cycle later, never unasked
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rvalid_o <= 1'b0;
    else
      rvalid_o <= cmd_i.rd;
  end

  // query answers, one cycle after the read
  // eight bit parts come back in the low byte, upper byte zero
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_o <= `SER_RST_WORD;
    else
    begin
      if (cmd_i.rd)
      begin
        unique case (cmd_i.sel)
          `SER_SEL_EVT_STAT:  rdata_o <= {8'h00, esr_q};
          `SER_SEL_EVT_EN:    rdata_o <= {8'h00, ese_q};
          `SER_SEL_SRQ_EN:    rdata_o <= {8'h00, sre_q};
          `SER_SEL_STB:       rdata_o <= {8'h00, stb};
          `SER_SEL_QUES_COND: rdata_o <= `SER_RST_WORD;
          `SER_SEL_QUES_EVT:  rdata_o <= ques_evt;
          `SER_SEL_OPER_COND: rdata_o <= oper_cond;
          `SER_SEL_OPER_EVT:  rdata_o <= oper_evt;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/ser_ctrl_model.sv ***
// remote controller model: queries, settings and serial poll
`timescale 1ns/1ps
`default_nettype none
module ser_ctrl_model (
  // clock
  input  wire logic             clk_i,
  // command side
  output var ser_pkg::ser_cmd_s cmd_o,
  input  wire logic      [15:0] rdata_i,
  input  wire logic             rvalid_i,
  // poll side
  output logic                  spoll_o,
  input  wire logic       [7:0] spoll_byte_i,
  input  wire logic             spoll_valid_i,
  // an answer was missing
  output logic                  hung_o
);
  // idle: strobes low
  initial
  begin
    cmd_o = '0;
    spoll_o = 1'b0;
    hung_o = 1'b0;
  end
  // setting command, taken at the next edge
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk_i) #1;
    cmd_o = '{1'b1, 1'b0, s, d};
    @(posedge clk_i) #1;
    cmd_o.wr = 1'b0;
    cmd_o.wdata = ~d; // released data must not look valid
  endtask
  // query: the answer stands just after the taking edge
  task automatic rd(input logic [2:0] s, output logic [15:0] d);
    @(posedge clk_i) #1;
    cmd_o.sel = s;
    cmd_o.rd = 1'b1;
    @(posedge clk_i) #1;
    cmd_o.rd = 1'b0;
    d = rdata_i;
    if (!rvalid_i)
      hung_o = 1'b1;
  endtask
  // serial poll by interface message, no command used
  task automatic poll(output logic [7:0] b);
    @(posedge clk_i) #1;
    spoll_o = 1'b1;
    @(posedge clk_i) #1;
    spoll_o = 1'b0;
    b = spoll_byte_i;
    if (!spoll_valid_i)
      hung_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** bench/ser_status_sva.sv ***
// port checker for the status reporting block
`timescale 1ns/1ps
`default_nettype none
module ser_status_sva (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // watched ports
  input  wire ser_pkg::ser_cmd_s cmd_i,
  input  wire logic      [15:0] rdata_o,
  input  wire logic             rvalid_o,
  input  wire ser_pkg::ser_evt_s evt_i,
  input  wire logic             calibrating_i,
  input  wire logic             err_queue_nonempty_i,
  input  wire logic             msg_avail_i,
  input  wire logic             spoll_i,
  input  wire logic       [7:0] spoll_byte_o,
  input  wire logic             spoll_valid_o,
  input  wire ser_pkg::ser_err_e err_class_o,
  input  wire logic             err_push_o,
  input  wire logic             srq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // answers come one cycle after the request, never unasked
  property p_rd; rvalid_o == $past(cmd_i.rd); endproperty
  a_rd: assert property (p_rd) else $error("read answer");
  property p_sp; spoll_valid_o == $past(spoll_i); endproperty
  a_sp: assert property (p_sp) else $error("poll answer");
  // error classes, command error first
  property p_cme;
    evt_i.cmd_err |=> err_push_o && err_class_o == ser_pkg::SER_ERR_CMD;
  endproperty
  a_cme: assert property (p_cme) else $error("cmd class");
  property p_exe;
    evt_i.exe_err && !evt_i.cmd_err |=>
      err_push_o && err_class_o == ser_pkg::SER_ERR_EXE;
  endproperty
  a_exe: assert property (p_exe) else $error("exe class");
  property p_dde;
    evt_i.dev_err && !evt_i.exe_err && !evt_i.cmd_err |=>
      err_push_o && err_class_o == ser_pkg::SER_ERR_DEV;
  endproperty
  a_dde: assert property (p_dde) else $error("dev class");
  property p_nop;
    !(evt_i.dev_err || evt_i.exe_err || evt_i.cmd_err) |=> !err_push_o;
  endproperty
  a_nop: assert property (p_nop) else $error("stray push");
  // status byte layout on a poll
  property p_stb;
    spoll_valid_o |-> spoll_byte_o[1:0] == 2'h0 &&
      spoll_byte_o[2] == $past(err_queue_nonempty_i) &&
      spoll_byte_o[4] == $past(msg_avail_i);
  endproperty
  a_stb: assert property (p_stb) else $error("byte map");
  // calibration shows live; other bits stay empty
  property p_opc;
    rvalid_o && $past(cmd_i.sel) == 3'h6 &&
      $past(calibrating_i, 2) == $past(calibrating_i) |->
      rdata_o == {15'h0000, $past(calibrating_i)};
  endproperty
  a_opc: assert property (p_opc) else $error("oper cond");
  property p_qs;
    rvalid_o && $past(cmd_i.sel) inside {3'h4, 3'h5} |-> rdata_o == 16'h0;
  endproperty
  a_qs: assert property (p_qs) else $error("ques bits");
  c_srq: cover property ($rose(srq_o));
  c_mss: cover property (spoll_valid_o && spoll_byte_o[6]);
  c_cal: cover property (rvalid_o && rdata_o[0] && $past(cmd_i.sel) == 3'h6);
endmodule
bind ser_status ser_status_sva u_sva (.*);
`default_nettype wire

// *** bench/ser_status_tb_top.sv ***
// self-checking bench for the status reporting block
`timescale 1ns/1ps
`default_nettype none
module ser_status_tb_top;
  logic              clk_i;
  logic              rst_n_i;
  ser_pkg::ser_cmd_s cmd;
  ser_pkg::ser_evt_s ev;
  logic              idle, cal, errq, mav, sp, rv, sv, srq, hung;
  logic [15:0]       rdata, got;
  logic [7:0]        sb, pb;
  int                errors, comparisons;
  // expected event bit per evt_i position, lsb first
  logic [7:0]        exp_bit [0:6] =
    '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h04, 8'h01};
  ser_status u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd),
    .rdata_o(rdata), .rvalid_o(rv), .evt_i(ev), .cmds_idle_i(idle),
    .calibrating_i(cal), .err_queue_nonempty_i(errq), .msg_avail_i(mav),
    .spoll_i(sp), .spoll_byte_o(sb), .spoll_valid_o(sv),
    .err_class_o(), .err_push_o(), .srq_o(srq));
  ser_ctrl_model u_ctl (.clk_i(clk_i), .cmd_o(cmd), .rdata_i(rdata),
    .rvalid_i(rv), .spoll_o(sp), .spoll_byte_i(sb), .spoll_valid_i(sv),
    .hung_o(hung));
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [15:0] e, s);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input string n, input logic [2:0] s,
                      input logic [15:0] e);
    u_ctl.rd(s, got);
    chk(n, e, got);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // one-cycle event pulse on position k
  task automatic pulse(input int k);
    cyc(1);
    ev[k] = 1'b1;
    cyc(1);
    ev = '0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // a missing answer ends the run
  always @(posedge hung)
  begin
    errors++;
    tally_and_finish();
  end
  initial
  begin
    ev = '0;
    {idle, cal, errq, mav} = 4'h8;
    errors = 0;
    comparisons = 0;
    rst_n_i = 1'b0;
    cyc(8);
    rst_n_i = 1'b1;
    rchk("esr", 3'h0, 16'h0080);
    rchk("esr", 3'h0, 16'h0000);
    rchk("ques", 3'h5, 16'h0000);
    rchk("qcond", 3'h4, 16'h0000);
    u_ctl.wr(3'h1, 8'hff);
    u_ctl.wr(3'h0, 8'hff);
    rchk("ese", 3'h1, 16'h00ff);
    rchk("esr", 3'h0, 16'h0000);
    $display("test reset and masks done");
    for (int k = 0; k < 7; k++)
    begin
      pulse(k);
      rchk("esr", 3'h0, {8'h00, exp_bit[k]});
    end
    // completion waits for the earlier commands
    idle = 1'b0;
    pulse(6);
    rchk("esr", 3'h0, 16'h0000);
    idle = 1'b1;
    cyc(2);
    rchk("esr", 3'h0, 16'h0001);
    $display("test events done");
    u_ctl.wr(3'h1, 8'h01);
    u_ctl.wr(3'h2, 8'h20);
    pulse(6);
    cyc(3);
    chk("srq", 16'h0001, {15'h0, srq});
    u_ctl.poll(pb);
    chk("poll", 16'h0060, {8'h00, pb});
    rchk("stb", 3'h3, 16'h0060);
    rchk("esr", 3'h0, 16'h0001);
    cyc(2);
    chk("srq", 16'h0000, {15'h0, srq});
    u_ctl.wr(3'h2, 8'h34);
    errq = 1'b1;
    mav = 1'b1;
    cyc(2);
    chk("srq", 16'h0001, {15'h0, srq});
    u_ctl.poll(pb);
    chk("poll", 16'h0054, {8'h00, pb});
    $display("test service request done");
    cal = 1'b1;
    cyc(2);
    rchk("opcond", 3'h6, 16'h0001);
    cal = 1'b0;
    rchk("opevt", 3'h7, 16'h0001);
    rchk("opevt", 3'h7, 16'h0000);
    $display("test operation done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
